// [rtl/rft_frame_fifo.v]
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "rft_consts.vh"
// Behaviour
// - query command always sends calibration period
// - force bit adds calibration to plain transmits
// - query session field from settings bits 1:0
// - count bits 11:4 from first length register
// - count bits 3:0 from second register top
// - send only partial-byte bits after full bytes
// - one fifo port, two cyclic 24-byte buffers
// - flag overflow when over 24 bytes loaded
// - five-bit fill count, all ones on empty read
// - transmit-active bit high during transmission
module rft_frame_fifo #(
  parameter BUF_BYTES = 24,
  parameter BIT_DIV   = 8
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        en,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output wire        irq,
  output reg         tx_active,
  output reg         tx_bit,
  output reg         tx_bit_strobe,
  output reg         tx_trcal,
  output reg         tx_query,
  output reg  [1:0]  tx_session
);

  // ========================================================
  // sizes and states
  // ========================================================
  localparam [4:0] BUF_CNT  = BUF_BYTES[4:0];          // one buffer
  localparam [5:0] PTR_LAST = {BUF_CNT, 1'b0} - 6'h01; // two buffers
  localparam [7:0] DIV_LAST = BIT_DIV[7:0] - 8'h01;
  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_PRE   = 3'h1;
  localparam [2:0] S_LOAD  = 3'h2;
  localparam [2:0] S_LATCH = 3'h3;
  localparam [2:0] S_DATA  = 3'h4;
  localparam [2:0] S_CRC   = 3'h5;
  localparam [2:0] S_DONE  = 3'h6;

  // ========================================================
  // declarations
  // ========================================================
  reg  [7:0]  settings_reg;     // crc type, force, session
  reg  [7:0]  len1_reg;         // full-byte count 11:4
  reg  [7:0]  len2_reg;         // count 3:0, partial bits
  reg  [7:0]  irq_stat_reg;     // sticky events
  reg  [7:0]  irq_mask_reg;     // interrupt enables
  reg  [5:0]  wr_ptr_reg;       // fill side pointer
  reg  [5:0]  rd_ptr_reg;       // drain side pointer
  reg  [4:0]  count_reg;        // unread bytes
  reg         ovf_reg;          // fifo overflow flag
  reg         empty_rd_reg;     // empty fifo was read
  reg  [2:0]  state_reg;        // transmit sequencer
  reg  [7:0]  sh_reg;           // byte being sent
  reg  [14:0] bits_left_reg;    // payload bits to go
  reg  [2:0]  bidx_reg;         // bit within byte
  reg  [4:0]  crc_left_reg;     // crc bits to go
  reg         use_crc_reg;      // frame carries a crc
  reg         crc5_reg;         // crc width of this frame
  reg  [7:0]  div_reg;          // bit rate divider
  wire [7:0]  idx;              // register word index
  wire        acc;              // apb access phase
  wire        wr;               // write access
  wire        rd;               // read access
  wire        mapped;           // index decodes
  wire [7:0]  mem_rdata;        // byte at read pointer
  wire [11:0] tx_full_byte_count;
  wire [2:0]  partial_byte_bit_count;
  wire [14:0] total_bits;       // whole payload in bits
  wire        cmd_wr;           // command register written
  wire        plain_tx;         // 90h or 91h
  wire        query_tx;         // 98h
  wire        start;            // frame begins
  wire        fifo_clr;         // fifo clear command
  wire        push_req;         // host writes fifo port
  wire        push;             // accepted write
  wire        ovf_evt;          // write beyond one buffer
  wire        host_pop;         // host read consumes a byte
  wire        empty_evt;        // host read of empty fifo
  wire        tx_pop;           // sequencer takes a byte
  wire        pop;
  wire        bit_en;           // one pulse per bit time
  wire        done_evt;         // frame finished
  wire        crc_bit;          // crc bit to send
  wire        crc_init;
  wire        crc_calc;
  wire        crc_shift;
  wire [4:0]  fifo_fill_count;
  wire        force_calibration_period;
  wire        crc_width_select;
  wire        session_select_high;
  wire        session_select_low;

  // ========================================================
  // apb slave decode
  // ========================================================
  assign idx     = paddr[9:2];
  assign acc     = psel & penable;
  assign wr      = acc & pwrite;
  assign rd      = acc & ~pwrite;
  assign mapped  = (paddr[11:10] == 2'b00) &&
                   (idx == `RFT_IDX_FIFO_STAT || idx == `RFT_IDX_SET ||
                    idx == `RFT_IDX_LEN1 || idx == `RFT_IDX_LEN2 ||
                    idx == `RFT_IDX_FIFO || idx == `RFT_IDX_CMD ||
                    idx == `RFT_IDX_IRQ_STAT || idx == `RFT_IDX_IRQ_MASK);
  // zero wait states: read data is already registered
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // ========================================================
  // field views
  // ========================================================
  assign crc_width_select         = settings_reg[`RFT_SET_CRC5];
  assign force_calibration_period = settings_reg[`RFT_SET_TRCAL];
  assign session_select_high      = settings_reg[`RFT_SET_SESS_HI];
  assign session_select_low       = settings_reg[`RFT_SET_SESS_LO];
  // count built from both length registers
  assign tx_full_byte_count = {len1_reg, len2_reg[`RFT_LEN2_LOW_HI:`RFT_LEN2_LOW_LO]};
  assign partial_byte_bit_count = len2_reg[`RFT_LEN2_BB_HI:`RFT_LEN2_BB_LO];
  assign total_bits = {tx_full_byte_count, 3'b000} + {12'h000, partial_byte_bit_count};

  // ========================================================
  // commands
  // ========================================================
  assign cmd_wr   = wr & (idx == `RFT_IDX_CMD);
  assign plain_tx = (pwdata[7:0] == `RFT_CMD_TX_CRC) | (pwdata[7:0] == `RFT_CMD_TX_NOCRC);
  assign query_tx = (pwdata[7:0] == `RFT_CMD_QUERY);
  // a transmit command during a frame is dropped, not queued
  assign start    = en & cmd_wr & (state_reg == S_IDLE) & (plain_tx | query_tx);
  assign fifo_clr = cmd_wr & (pwdata[7:0] == `RFT_CMD_FIFO_CLR);

  // ========================================================
  // configuration and interrupt registers
  // ========================================================
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settings_reg <= `RFT_REG_RESET;
      len1_reg     <= `RFT_REG_RESET;
      len2_reg     <= `RFT_REG_RESET;
      irq_mask_reg <= `RFT_REG_RESET;
      irq_stat_reg <= `RFT_REG_RESET;
    end else if (!en) begin
      // enable low holds everything in reset
      settings_reg <= `RFT_REG_RESET;
      len1_reg     <= `RFT_REG_RESET;
      len2_reg     <= `RFT_REG_RESET;
      irq_mask_reg <= `RFT_REG_RESET;
      irq_stat_reg <= `RFT_REG_RESET;
    end else begin
      if (wr && idx == `RFT_IDX_SET) begin
        // reserved bits stay zero
        settings_reg <= pwdata[7:0] & `RFT_SET_WMASK;
      end
      if (wr && idx == `RFT_IDX_LEN1) begin
        len1_reg <= pwdata[7:0];
      end
      if (wr && idx == `RFT_IDX_LEN2) begin
        len2_reg <= pwdata[7:0] & `RFT_LEN2_WMASK;
      end
      if (wr && idx == `RFT_IDX_IRQ_MASK) begin
        irq_mask_reg <= pwdata[7:0] & `RFT_IRQ_WMASK;
      end
      // write one to clear; a new event wins over the clear
      irq_stat_reg <= ((wr && idx == `RFT_IDX_IRQ_STAT) ? (irq_stat_reg & ~pwdata[7:0]) : irq_stat_reg)
                      | {6'h00, ovf_evt, done_evt};
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ========================================================
  // fifo bookkeeping
  // ========================================================
  assign push_req  = wr & (idx == `RFT_IDX_FIFO);
  assign push      = push_req & (count_reg < BUF_CNT);
  assign ovf_evt   = en & push_req & ~(count_reg < BUF_CNT);
  // host reads during a frame do not consume, the sequencer owns the read side
  assign host_pop  = rd & (idx == `RFT_IDX_FIFO) & (state_reg == S_IDLE) & (count_reg != 5'h00);
  assign empty_evt = rd & (idx == `RFT_IDX_FIFO) & (count_reg == 5'h00);
  assign tx_pop    = (state_reg == S_LOAD) & (bits_left_reg != 15'h0000) & (count_reg != 5'h00);
  assign pop       = host_pop | tx_pop;
  assign fifo_fill_count = empty_rd_reg ? `RFT_FILL_EMPTY : count_reg;

  // pointers wrap over both buffers, giving the cyclic fill
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_reg   <= 6'h00;
      rd_ptr_reg   <= 6'h00;
      count_reg    <= 5'h00;
      ovf_reg      <= 1'b0;
      empty_rd_reg <= 1'b0;
    end else if (!en || fifo_clr) begin
      wr_ptr_reg   <= 6'h00;
      rd_ptr_reg   <= 6'h00;
      count_reg    <= 5'h00;
      ovf_reg      <= 1'b0;
      empty_rd_reg <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? 6'h00 : wr_ptr_reg + 6'h01;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? 6'h00 : rd_ptr_reg + 6'h01;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 5'h01;
      end else if (pop && !push) begin
        count_reg <= count_reg - 5'h01;
      end
      if (ovf_evt) begin
        ovf_reg <= 1'b1;
      end
      // empty-read marker lasts until new data arrive
      if (empty_evt) begin
        empty_rd_reg <= 1'b1;
      end else if (push) begin
        empty_rd_reg <= 1'b0;
      end
    end
  end

  rft_mem #(
    .WIDTH (8),
    .DEPTH (2 * BUF_BYTES),
    .AW    (6)
  ) u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (push & en & ~fifo_clr),
    .wr_addr (wr_ptr_reg),
    .wr_data (pwdata[7:0]),
    .rd_addr (rd_ptr_reg),
    .rd_data (mem_rdata)
  );

  // ========================================================
  // read mux
  // ========================================================
  always @* begin
    prdata = 32'h00000000;
    case (idx)
      `RFT_IDX_FIFO_STAT: prdata[7:0] = {tx_active, 1'b0, ovf_reg, fifo_fill_count};
      `RFT_IDX_SET:       prdata[7:0] = settings_reg;
      `RFT_IDX_LEN1:      prdata[7:0] = len1_reg;
      `RFT_IDX_LEN2:      prdata[7:0] = len2_reg;
      `RFT_IDX_FIFO:      prdata[7:0] = mem_rdata;
      `RFT_IDX_IRQ_STAT:  prdata[7:0] = irq_stat_reg;
      `RFT_IDX_IRQ_MASK:  prdata[7:0] = irq_mask_reg;
      default:            prdata = 32'h00000000;
    endcase
  end

  // ========================================================
  // bit rate divider
  // ========================================================
  assign bit_en = (div_reg == DIV_LAST);

  // restarts with each frame so the first bit is a full period
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 8'h00;
    end else if (!en || start || bit_en) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // ========================================================
  // crc generator
  // ========================================================
  assign crc_init  = start;
  assign crc_calc  = (state_reg == S_DATA) & bit_en;
  assign crc_shift = (state_reg == S_CRC) & bit_en;

  rft_crc u_crc (
    .pclk    (pclk),
    .presetn (presetn),
    .init    (crc_init),
    .crc5    (start ? crc_width_select : crc5_reg),
    .calc    (crc_calc),
    .shift   (crc_shift),
    .din     (sh_reg[7]),
    .crc_bit (crc_bit)
  );

  assign done_evt = en & (state_reg == S_DONE);

  // ========================================================
  // transmit sequencer
  // ========================================================
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= S_IDLE;
      sh_reg        <= 8'h00;
      bits_left_reg <= 15'h0000;
      bidx_reg      <= 3'h0;
      crc_left_reg  <= 5'h00;
      use_crc_reg   <= 1'b0;
      crc5_reg      <= 1'b0;
      tx_active     <= 1'b0;
      tx_bit        <= 1'b0;
      tx_bit_strobe <= 1'b0;
      tx_trcal      <= 1'b0;
      tx_query      <= 1'b0;
      tx_session    <= 2'b00;
    end else if (!en) begin
      state_reg     <= S_IDLE;
      tx_active     <= 1'b0;
      tx_bit_strobe <= 1'b0;
      tx_trcal      <= 1'b0;
      tx_query      <= 1'b0;
    end else begin
      tx_bit_strobe <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (start) begin
            bits_left_reg <= total_bits;
            bidx_reg      <= 3'h0;
            use_crc_reg   <= (pwdata[7:0] != `RFT_CMD_TX_NOCRC);
            crc5_reg      <= crc_width_select;
            crc_left_reg  <= crc_width_select ? `RFT_CRC5_LEN : `RFT_CRC16_LEN;
            tx_active     <= 1'b1;
            tx_query      <= query_tx;
            if (query_tx) begin
              tx_session <= {session_select_high, session_select_low};
            end
            // query always, plain transmits only when forced
            if (query_tx || force_calibration_period) begin
              tx_trcal  <= 1'b1;
              state_reg <= S_PRE;
            end else begin
              state_reg <= S_LOAD;
            end
          end
        end
        S_PRE: begin
          // calibration period lasts one bit time
          if (bit_en) begin
            tx_trcal  <= 1'b0;
            state_reg <= S_LOAD;
          end
        end
        S_LOAD: begin
          if (bits_left_reg == 15'h0000) begin
            state_reg <= use_crc_reg ? S_CRC : S_DONE;
          end else if (count_reg != 5'h00) begin
            state_reg <= S_LATCH;
          end
          // an empty fifo stalls here until the host refills it
        end
        S_LATCH: begin
          sh_reg    <= mem_rdata;
          state_reg <= S_DATA;
        end
        S_DATA: begin
          if (bit_en) begin
            tx_bit        <= sh_reg[7];
            tx_bit_strobe <= 1'b1;
            sh_reg        <= {sh_reg[6:0], 1'b0};
            bits_left_reg <= bits_left_reg - 15'h0001;
            bidx_reg      <= bidx_reg + 3'h1;
            // stopping on the bit count trims the last byte
            if (bits_left_reg == 15'h0001) begin
              state_reg <= use_crc_reg ? S_CRC : S_DONE;
            end else if (bidx_reg == 3'h7) begin
              state_reg <= S_LOAD;
            end
          end
        end
        S_CRC: begin
          if (bit_en) begin
            tx_bit        <= crc_bit;
            tx_bit_strobe <= 1'b1;
            crc_left_reg  <= crc_left_reg - 5'h01;
            if (crc_left_reg == 5'h01) begin
              state_reg <= S_DONE;
            end
          end
        end
        S_DONE: begin
          tx_active <= 1'b0;
          tx_query  <= 1'b0;
          state_reg <= S_IDLE;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// [rtl/rft_consts.vh]
`ifndef RFT_CONSTS_VH
`define RFT_CONSTS_VH

// ==========================================================
// register word indices (byte address = index * 4)
// ==========================================================
`define RFT_IDX_FIFO_STAT 8'h39
`define RFT_IDX_SET       8'h3C
`define RFT_IDX_LEN1      8'h3D
`define RFT_IDX_LEN2      8'h3E
`define RFT_IDX_FIFO      8'h3F
`define RFT_IDX_CMD       8'h40
`define RFT_IDX_IRQ_STAT  8'h41
`define RFT_IDX_IRQ_MASK  8'h42

// ==========================================================
// direct command codes
// ==========================================================
`define RFT_CMD_TX_CRC    8'h90
`define RFT_CMD_TX_NOCRC  8'h91
`define RFT_CMD_QUERY     8'h98
`define RFT_CMD_FIFO_CLR  8'h83

// ==========================================================
// field layouts and reset values
// ==========================================================
`define RFT_SET_CRC5      3
`define RFT_SET_TRCAL     2
`define RFT_SET_SESS_HI   1
`define RFT_SET_SESS_LO   0
`define RFT_SET_WMASK     8'h0F
`define RFT_LEN2_WMASK    8'hFE
`define RFT_LEN2_LOW_HI   7
`define RFT_LEN2_LOW_LO   4
`define RFT_LEN2_BB_HI    3
`define RFT_LEN2_BB_LO    1
`define RFT_IRQ_DONE      0
`define RFT_IRQ_OVF       1
`define RFT_IRQ_WMASK     8'h03
`define RFT_REG_RESET     8'h00
`define RFT_FILL_EMPTY    5'h1F

// ==========================================================
// crc constants
// ==========================================================
`define RFT_CRC16_POLY    16'h1021
`define RFT_CRC16_PRESET  16'hFFFF
`define RFT_CRC5_POLY     5'h09
`define RFT_CRC5_PRESET   5'h09
`define RFT_CRC16_LEN     5'h10
`define RFT_CRC5_LEN      5'h05

`endif

// [rtl/rft_mem.v]
`timescale 1ns/1ps
// ==========================================================
// byte store for the two cyclic buffers
// ==========================================================
module rft_mem #(
  parameter WIDTH = 8,
  parameter DEPTH = 48,
  parameter AW    = 6
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire             wr_en,
  input  wire [AW-1:0]    wr_addr,
  input  wire [WIDTH-1:0] wr_data,
  input  wire [AW-1:0]    rd_addr,
  output reg  [WIDTH-1:0] rd_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];  // storage, no reset needed

  // write port
  always @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read, follows the address one cycle late
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= {WIDTH{1'b0}};
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// [rtl/rft_crc.v]
`timescale 1ns/1ps
`include "rft_consts.vh"
// ==========================================================
// serial crc-16 / crc-5 generator
// ==========================================================
module rft_crc (
  input  wire pclk,
  input  wire presetn,
  input  wire init,
  input  wire crc5,
  input  wire calc,
  input  wire shift,
  input  wire din,
  output wire crc_bit
);

  reg  [15:0] crc_reg;   // crc-5 lives in bits 4:0
  reg  [15:0] crc_next;
  wire        fb16;      // crc-16 feedback
  wire        fb5;       // crc-5 feedback

  assign fb16 = crc_reg[15] ^ din;
  assign fb5  = crc_reg[4] ^ din;
  // crc-16 leaves inverted, crc-5 leaves as it is
  assign crc_bit = crc5 ? crc_reg[4] : ~crc_reg[15];

  // next value
  always @* begin
    crc_next = crc_reg;
    if (init) begin
      crc_next = crc5 ? {11'h000, `RFT_CRC5_PRESET} : `RFT_CRC16_PRESET;
    end else if (calc && crc5) begin
      crc_next = {11'h000, crc_reg[3:0], 1'b0} ^ {11'h000, (fb5 ? `RFT_CRC5_POLY : 5'h00)};
    end else if (calc) begin
      crc_next = {crc_reg[14:0], 1'b0} ^ (fb16 ? `RFT_CRC16_POLY : 16'h0000);
    end else if (shift) begin
      crc_next = {crc_reg[14:0], 1'b0};
    end
  end

  // state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_reg <= `RFT_CRC16_PRESET;
    end else begin
      crc_reg <= crc_next;
    end
  end

endmodule

// [test/rft_frame_fifo_asserts.sv]
`timescale 1ns/1ps
// ==========================================================
// port checker for the framer and fifo block
// ==========================================================
module rft_frame_fifo_chk #(
  parameter BIT_DIV = 8
) (
  input wire        pclk,
  input wire        presetn,
  input wire        en,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        tx_active,
  input wire        tx_bit_strobe,
  input wire        tx_trcal,
  input wire        tx_query,
  input wire [1:0]  tx_session
);
  reg  [7:0] gap;  // cycles since last bit strobe, saturating
  wire       acc;  // apb access phase
  assign acc = psel && penable;
  // gap counter, saturates so idle time never wraps
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) gap <= 8'hFF;
    else if (tx_bit_strobe) gap <= 8'h00;
    else if (gap != 8'hFF) gap <= gap + 8'h01;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; acc |-> pready && (prdata[31:8] == 24'h000000); endproperty
  a_ready: assert property (p_ready) else $error("bad apb answer");
  property p_err; pslverr |-> acc && (paddr[11:10] != 2'b00 ||
    (paddr[9:2] != 8'h39 && (paddr[9:2] < 8'h3C || paddr[9:2] > 8'h42))); endproperty
  a_err: assert property (p_err) else $error("slave error on mapped place");
  property p_stat; acc && !pwrite && paddr == 12'h0E4 |-> prdata[7] == tx_active; endproperty
  a_stat: assert property (p_stat) else $error("status busy bit wrong");
  property p_strobe; tx_bit_strobe |-> tx_active && gap >= BIT_DIV - 1; endproperty
  a_strobe: assert property (p_strobe) else $error("bit strobe out of frame or early");
  property p_trcal; tx_trcal |-> tx_active && !tx_bit_strobe; endproperty
  a_trcal: assert property (p_trcal) else $error("calibration outside preamble");
  property p_query; tx_query |-> tx_active; endproperty
  a_query: assert property (p_query) else $error("query flag without frame");
  property p_sess; tx_query && $past(tx_query) |-> $stable(tx_session); endproperty
  a_sess: assert property (p_sess) else $error("session changed in frame");
  property p_en; !en |=> !tx_active [*2]; endproperty
  a_en: assert property (p_en) else $error("busy while disabled");
endmodule
bind rft_frame_fifo rft_frame_fifo_chk #(.BIT_DIV(BIT_DIV)) u_chk (.pclk(pclk), .presetn(presetn), .en(en),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .tx_active(tx_active), .tx_bit_strobe(tx_bit_strobe), .tx_trcal(tx_trcal),
  .tx_query(tx_query), .tx_session(tx_session));

// [test/rft_host_model.sv]
`timescale 1ns/1ps
// ==========================================================
// host model: apb master, one byte per access
// ==========================================================
module rft_host (
  input  wire        pclk,
  output reg         psel,
  output reg         penable,
  output reg         pwrite,
  output reg  [11:0] paddr,
  output reg  [31:0] pwdata,
  input  wire [31:0] prdata,
  input  wire        pready,
  input  wire        pslverr
);
  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
  end
  // one transfer; holds the request until pready, waits with no cycle count assumed
  task xfer(input w, input [11:0] a, input [7:0] d, output [7:0] q, output e);
    begin
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      // no assumed count; the answer is taken at the edge that sees pready high
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata[7:0];
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
    end
  endtask
  task wr(input [11:0] a, input [7:0] d);
    reg [7:0] q; reg e;
    begin
      xfer(1'b1, a, d, q, e);
    end
  endtask
endmodule

// [test/tb_top.sv]
`timescale 1ns/1ps
`include "rft_consts.vh"
// ==========================================================
// self-checking bench
// ==========================================================
module tb_top;
  localparam [11:0] A_STAT = `RFT_IDX_FIFO_STAT * 4, A_SET = `RFT_IDX_SET * 4, A_LEN1 = `RFT_IDX_LEN1 * 4;
  localparam [11:0] A_LEN2 = `RFT_IDX_LEN2 * 4, A_FIFO = `RFT_IDX_FIFO * 4, A_CMD = `RFT_IDX_CMD * 4;
  localparam [11:0] A_IRQ = `RFT_IDX_IRQ_STAT * 4, A_MASK = `RFT_IDX_IRQ_MASK * 4;
  reg         pclk = 1'b0, presetn = 1'b0, en = 1'b0;
  wire        psel, penable, pwrite, pready, pslverr, irq, tx_active, tx_bit, tx_bit_strobe, tx_trcal, tx_query;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  wire [1:0]  tx_session;
  integer     mismatches = 0, n_checks = 0, cyc = 0, nstb = 0, i, k;
  reg  [10:0] dbits;              // first data bits of a frame
  reg         tseen, qseen, e;    // calibration / query seen, slave error
  reg  [1:0]  sess;               // session captured during a query frame
  reg  [7:0]  d;
  reg  [7:0]  set_t [0:3];        // settings per frame case
  reg  [7:0]  cmd_t [0:3];        // command per frame case
  integer     stb_t [0:3];        // strobes: data bits plus crc bits
  always #10 pclk = ~pclk;
  rft_frame_fifo #(.BUF_BYTES(24), .BIT_DIV(2)) dut (.pclk(pclk), .presetn(presetn), .en(en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .tx_active(tx_active), .tx_bit(tx_bit), .tx_bit_strobe(tx_bit_strobe),
    .tx_trcal(tx_trcal), .tx_query(tx_query), .tx_session(tx_session));
  rft_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // frame monitor on the serial side
  always @(posedge pclk) begin
    if (tx_bit_strobe === 1'b1) begin
      nstb <= nstb + 1;
      if (nstb < 11) dbits <= {dbits[9:0], tx_bit};
    end
    if (tx_trcal === 1'b1) tseen <= 1'b1;
    if (tx_query === 1'b1) begin
      qseen <= 1'b1;
      sess  <= tx_session;
    end
  end
  // hang guard, well above the expected run
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      tally_and_finish;
    end
  end
  task check(input [8*8-1:0] nm, input [31:0] exp, input [31:0] got);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("unexpected %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task rd_chk(input [11:0] a, input [7:0] exp);
    begin
      host.xfer(1'b0, a, 8'h00, d, e);
      check("rdata", exp, d);
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    set_t[0] = 8'h0B; cmd_t[0] = 8'h98; stb_t[0] = 16;
    set_t[1] = 8'h00; cmd_t[1] = 8'h91; stb_t[1] = 11;
    set_t[2] = 8'h04; cmd_t[2] = 8'h90; stb_t[2] = 27;
    set_t[3] = 8'h01; cmd_t[3] = 8'h90; stb_t[3] = 27;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    en      <= 1'b1;
    // reset values, then reserved bits read back as zero
    rd_chk(A_SET, 8'h00);
    rd_chk(A_LEN1, 8'h00);
    rd_chk(A_LEN2, 8'h00);
    host.wr(A_SET, 8'hFF);
    rd_chk(A_SET, 8'h0F);
    host.wr(A_LEN1, 8'hFF);
    rd_chk(A_LEN1, 8'hFF);
    host.wr(A_LEN2, 8'hFF);
    rd_chk(A_LEN2, 8'hFE);
    host.xfer(1'b0, 12'h000, 8'h00, d, e);
    check("slverr", 1, e);
    // fill past one buffer: overflow flag, interrupt mask and clear
    host.wr(A_MASK, 8'h02);
    for (i = 0; i < 25; i = i + 1) host.wr(A_FIFO, i + 8'h10);
    rd_chk(A_STAT, 8'h38);
    check("irq_ovf", 1, irq);
    host.wr(A_MASK, 8'h00);
    @(posedge pclk);
    check("irq_mask", 0, irq);
    host.wr(A_MASK, 8'h02);
    host.wr(A_IRQ, 8'h02);
    @(posedge pclk);
    check("irq_clr", 0, irq);
    // drain in order, then read an empty fifo
    for (i = 0; i < 24; i = i + 1) rd_chk(A_FIFO, i + 8'h10);
    host.xfer(1'b0, A_FIFO, 8'h00, d, e);
    rd_chk(A_STAT, 8'h3F);
    host.wr(A_CMD, `RFT_CMD_FIFO_CLR);
    rd_chk(A_STAT, 8'h00);
    // one full byte plus three bits, every command and crc width
    host.wr(A_LEN1, 8'h00);
    host.wr(A_LEN2, 8'h16);
    host.wr(A_MASK, 8'h01);
    for (k = 0; k < 4; k = k + 1) begin
      host.wr(A_SET, set_t[k]);
      host.wr(A_FIFO, 8'hA5);
      host.wr(A_FIFO, 8'hC0);
      nstb <= 0; tseen <= 1'b0; qseen <= 1'b0;
      host.wr(A_CMD, cmd_t[k]);
      host.xfer(1'b0, A_STAT, 8'h00, d, e);
      check("busy", 1, d[7]);
      while (tx_active !== 1'b0) @(posedge pclk);
      @(posedge pclk);
      check("nbits", stb_t[k], nstb);
      check("data", 11'b10100101110, dbits);
      check("trcal", (k == 0 || k == 2), tseen);
      check("query", (k == 0), qseen);
      if (k == 0) check("session", 2'b11, sess);
      check("irq_done", 1, irq);
      host.wr(A_IRQ, 8'h01);
    end
    tally_and_finish;
  end
endmodule
